// ==== hw/tcd_ctrl.sv ====
// Control logic of a three-channel current-sink driver: dimming, standby, soft-start, faults.
// Assumes dimming inputs and fault sense levels are asynchronous pins; fault line is pulled up.
`timescale 1ns/1ps
// Overview of operation
// - Each sink conducts while its dimming input is high, independently, cycle by cycle.
// - Device is enabled while any dimming input is high.
// - All inputs low for more than 4ms enters standby.
// - Any dimming input activity leaves standby automatically.
// - Enabled channel current ramps over 200us when supply is good.
// - Open, short, over-temperature and undervoltage are monitored faults.
// - Any fault present pulls the active-low fault line low.
// - Open or short confirmed after 7 cycles or 3ms on; shuts all channels.
// - After shutdown recheck every 128ms and resume once cleared.
// - Fault line released once the open condition is removed.
// - Fault line only pulls low or floats.
module tcd_ctrl #(
	parameter int STANDBY_CYC   = tcd_pkg::STANDBY_CYC,
	parameter int SOFTSTART_CYC = tcd_pkg::SOFTSTART_CYC,
	parameter int DEGLITCH_CYC  = tcd_pkg::DEGLITCH_CYC,
	parameter int HICCUP_CYC    = tcd_pkg::HICCUP_CYC
) (
	input  wire logic                                    clk_sys,
	input  wire logic                                    reset_n,
	input  wire logic [tcd_pkg::NUM_CH-1:0]              dimmingInputs,
	input  wire logic [tcd_pkg::NUM_CH-1:0]              openSense,
	input  wire logic [tcd_pkg::NUM_CH-1:0]              shortSense,
	input  wire logic                                    overTempSense,
	input  wire logic                                    undervoltageLockout,
	output logic      [tcd_pkg::NUM_CH-1:0]              sinkOutputs,
	output logic      [tcd_pkg::NUM_CH*tcd_pkg::LEVEL_W-1:0] sinkLevel,
	output logic                                         standby,
	output logic                                         faultLineOut,
	output logic                                         faultLineOe
);
	localparam int NC = tcd_pkg::NUM_CH;
	localparam int LW = tcd_pkg::LEVEL_W;

	typedef enum logic [1:0] {RUN, STANDBY, PROTECT} tcd_mode_t;

	typedef struct packed {
		tcd_mode_t             mode;
		logic [31:0]           idleCnt;
		logic [31:0]           rampCnt;
		logic [31:0]           hiccupCnt;
		logic [NC-1:0][31:0]   onCnt;
		logic [NC-1:0][2:0]    pulseCnt;
		logic [NC-1:0]         dimPrev;
		logic [NC-1:0]         sinkOn;
		logic [NC-1:0][LW-1:0] level;
		logic                  faultLow;
		logic                  inStandby;
	} tcd_state_t;

	tcd_state_t st;
	tcd_state_t next_st;

	logic [NC-1:0] dimSync;
	logic [NC-1:0] openSync;
	logic [NC-1:0] shortSync;
	logic          otSync;
	logic          uvSync;

	for (genvar i = 0; i < NC; i++) begin : g_sync
		tcd_sync3 uDim (
			.clk_sys (clk_sys),
			.reset_n (reset_n),
			.asyncIn (dimmingInputs[i]),
			.syncOut (dimSync[i])
		);
		tcd_sync3 uOpen (
			.clk_sys (clk_sys),
			.reset_n (reset_n),
			.asyncIn (openSense[i]),
			.syncOut (openSync[i])
		);
		tcd_sync3 uShort (
			.clk_sys (clk_sys),
			.reset_n (reset_n),
			.asyncIn (shortSense[i]),
			.syncOut (shortSync[i])
		);
	end

	tcd_sync3 uOt (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.asyncIn (overTempSense),
		.syncOut (otSync)
	);
	tcd_sync3 uUv (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.asyncIn (undervoltageLockout),
		.syncOut (uvSync)
	);

	always_comb begin
		logic          anyOn;
		logic [NC-1:0] lineFault;
		logic [NC-1:0] confirm;
		logic          supplyOk;
		logic [LW-1:0] rampLevel;
		anyOn     = |dimSync;
		lineFault = openSync | shortSync;
		confirm   = '0;
		supplyOk  = !uvSync && !otSync;
		rampLevel = tcd_pkg::LEVEL_ZERO;
		next_st   = st;
		// Ramp level scales the elapsed soft-start time onto the level range
		if (st.rampCnt >= 32'(SOFTSTART_CYC)) begin
			rampLevel = tcd_pkg::LEVEL_FULL;
		end else begin
			rampLevel = LW'((64'(st.rampCnt) * 64'(tcd_pkg::LEVEL_FULL)) / 64'(SOFTSTART_CYC));
		end
		next_st.dimPrev = dimSync;

		// Deglitch of open/short per channel: counted pulses or continuous on-time
		for (int i = 0; i < NC; i++) begin
			if (!lineFault[i]) begin
				next_st.pulseCnt[i] = '0;
				next_st.onCnt[i]    = '0;
			end else if (dimSync[i] && st.mode == RUN) begin
				next_st.onCnt[i] = st.onCnt[i] + 32'h1;
				if (!st.dimPrev[i]) begin
					next_st.pulseCnt[i] = st.pulseCnt[i] + 3'h1;
				end
			end else begin
				next_st.onCnt[i] = '0;
			end
			if (st.pulseCnt[i] >= 3'(tcd_pkg::DEGLITCH_PULSES)
				|| st.onCnt[i] >= 32'(DEGLITCH_CYC)) begin
				confirm[i] = 1'b1;
			end
		end

		case (st.mode)
			RUN: begin
				// Idle count saturates at the standby threshold
				if (anyOn) begin
					next_st.idleCnt = '0;
				end else if (st.idleCnt < 32'(STANDBY_CYC)) begin
					next_st.idleCnt = st.idleCnt + 32'h1;
				end
				if (|confirm) begin
					next_st.mode      = PROTECT;
					next_st.hiccupCnt = '0;
					next_st.rampCnt   = '0;
					next_st.pulseCnt  = '0;
					next_st.onCnt     = '0;
				end else if (!anyOn && st.idleCnt >= 32'(STANDBY_CYC) - 32'h1) begin
					next_st.mode    = STANDBY;
					next_st.rampCnt = '0;
				end
				if (!supplyOk) begin
					next_st.rampCnt = '0;
				end else if (anyOn && st.rampCnt < 32'(SOFTSTART_CYC)) begin
					next_st.rampCnt = st.rampCnt + 32'h1;
				end
			end
			STANDBY: begin
				// Waking restarts the ramp so the string never sees a current step
				next_st.idleCnt = '0;
				next_st.rampCnt = '0;
				if (anyOn) begin
					next_st.mode = RUN;
				end
			end
			PROTECT: begin
				// Only open or short strings latch protection; OT and UV gate sinks directly
				if (st.hiccupCnt >= 32'(HICCUP_CYC) - 32'h1) begin
					next_st.hiccupCnt = '0;
					if (!(|lineFault)) begin
						next_st.mode    = RUN;
						next_st.idleCnt = '0;
						next_st.rampCnt = '0;
					end
				end else begin
					next_st.hiccupCnt = st.hiccupCnt + 32'h1;
				end
			end
			default: begin
				next_st.mode = RUN;
			end
		endcase

		next_st.inStandby = (next_st.mode == STANDBY);
		for (int i = 0; i < NC; i++) begin
			if (next_st.mode == RUN && supplyOk && dimSync[i]) begin
				next_st.sinkOn[i] = 1'b1;
				next_st.level[i]  = rampLevel;
			end else begin
				next_st.sinkOn[i] = 1'b0;
				next_st.level[i]  = tcd_pkg::LEVEL_ZERO;
			end
		end
		// Fault line follows the live fault state in every mode
		next_st.faultLow = (|lineFault) || otSync || uvSync;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st      <= '0;
			st.mode <= RUN;
		end else begin
			st <= next_st;
		end
	end

	assign sinkOutputs  = st.sinkOn;
	assign sinkLevel    = st.level;
	assign standby      = st.inStandby;
	assign faultLineOut = 1'b0;
	assign faultLineOe  = st.faultLow;
endmodule

// ==== hw/tcd_pkg.sv ====
// Constants for the three-channel dimming, standby and fault controller.
// Assumes a 100 MHz system clock.
package tcd_pkg;
	localparam int CLK_MHZ          = 100;
	localparam int NUM_CH           = 3;
	localparam int STANDBY_MS       = 4;
	localparam int STANDBY_CYC      = STANDBY_MS * 1000 * CLK_MHZ + 1;
	localparam int SOFTSTART_US     = 200;
	localparam int SOFTSTART_CYC    = SOFTSTART_US * CLK_MHZ;
	localparam int DEGLITCH_PULSES  = 7;
	localparam int DEGLITCH_FULL_MS = 3;
	localparam int DEGLITCH_CYC     = DEGLITCH_FULL_MS * 1000 * CLK_MHZ;
	localparam int HICCUP_MS        = 128;
	localparam int HICCUP_CYC       = HICCUP_MS * 1000 * CLK_MHZ;
	localparam int LEVEL_W          = 8;
	localparam logic [LEVEL_W-1:0] LEVEL_FULL = 8'hFF;
	localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 8'h00;
endpackage

// ==== hw/tcd_sync3.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module tcd_sync3 (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic asyncIn,
	output logic      syncOut
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} tcd_sync_state_t;

	tcd_sync_state_t st;
	tcd_sync_state_t next_st;

	always_comb begin
		next_st     = st;
		next_st.s1  = asyncIn;
		next_st.s2  = st.s1;
		next_st.s3  = st.s2;
		if (st.s2 == st.s3) begin
			next_st.out = st.s3;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign syncOut = st.out;
endmodule

// ==== bench/tcd_ctrl_sva.sv ====
// Port checker for tcd_ctrl.
// Assumes it is bound into tcd_ctrl by tb_top.
`timescale 1ns/1ps
module tcd_ctrl_sva #(
	parameter int STANDBY_CYC   = 50,
	parameter int SOFTSTART_CYC = 16
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [2:0]  dimmingInputs,
	input wire logic [2:0]  openSense,
	input wire logic [2:0]  shortSense,
	input wire logic        overTempSense,
	input wire logic        undervoltageLockout,
	input wire logic [2:0]  sinkOutputs,
	input wire logic [23:0] sinkLevel,
	input wire logic        standby,
	input wire logic        faultLineOut,
	input wire logic        faultLineOe
);
	localparam int RAMP_MAX = SOFTSTART_CYC + 8;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	int  lowCnt;
	wire anyF = |{openSense, shortSense, overTempSense, undervoltageLockout};
	// Length of the current all-low run on the raw pins
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n) lowCnt <= 0;
		else lowCnt <= (|dimmingInputs) ? 0 : lowCnt + 1;
	a_sink_in: assert property (sinkOutputs[0] |-> $past(dimmingInputs[0], 5))
		else $error("sink on with input low");
	a_sb_late: assert property ($rose(standby) |-> lowCnt > STANDBY_CYC)
		else $error("standby too early");
	a_wake: assert property (standby && (|dimmingInputs) |-> ##[1:8] !standby)
		else $error("standby not left");
	a_ramp_done: assert property ($fell(standby) && dimmingInputs[1] |->
		##[1:RAMP_MAX] sinkLevel[15:8] == 8'hFF) else $error("ramp not done");
	a_wake_ramp: assert property ($fell(standby) |->
		sinkLevel[7:0] < 8'h40 && sinkLevel[15:8] < 8'h40 && sinkLevel[23:16] < 8'h40)
		else $error("no ramp after wake");
	a_fault_pull: assert property (anyF [*3] |-> ##4 faultLineOe)
		else $error("fault not reported");
	a_fault_free: assert property (!anyF [*7] |=> !faultLineOe)
		else $error("fault line held");
	a_open_drain: assert property (faultLineOut == 1'b0)
		else $error("fault line driven high");
endmodule

// ==== bench/tcd_mcu_model.sv ====
// Controller model: drives the dimming pins, samples the fault line each cycle.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ps
module tcd_mcu_model (
	input  wire logic       clk_sys,
	input  wire logic [2:0] want,
	input  wire logic       gang,
	input  wire logic       faultLine_n,
	output logic      [2:0] dimPins = 3'h0,
	output logic            irqSeen = 1'b0
);
	always @(posedge clk_sys) begin
		dimPins <= gang ? {3{want[0]}} : want;
		irqSeen <= !faultLine_n;
	end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for tcd_ctrl with short timing parameters.
// Assumes a pull-up on the shared fault line.
`timescale 1ns/1ps
module tb_top;
	localparam int SB = 50, SS = 16, DG = 20, HC = 40, HOLD = 1000;
	logic        clk_sys = 0, reset_n = 0, gang = 0, ot = 0, uv = 0, fOut, fOe, sb, irq;
	logic [2:0]  want = 0, pins, open = 0, shrt = 0, sink, r;
	logic [23:0] lvl;
	logic [2:0]  expQ[$];
	int          error_cnt = 0, cmp_count = 0, seed = 32'h730b;
	wire         faultLine_n = fOe ? fOut : 1'b1;
	tcd_mcu_model mcu (.clk_sys(clk_sys), .want(want), .gang(gang), .faultLine_n(faultLine_n),
		.dimPins(pins), .irqSeen(irq));
	tcd_ctrl #(.STANDBY_CYC(SB), .SOFTSTART_CYC(SS), .DEGLITCH_CYC(DG), .HICCUP_CYC(HC)) uut (
		.clk_sys(clk_sys), .reset_n(reset_n), .dimmingInputs(pins), .openSense(open),
		.shortSense(shrt), .overTempSense(ot), .undervoltageLockout(uv), .sinkOutputs(sink),
		.sinkLevel(lvl), .standby(sb), .faultLineOut(fOut), .faultLineOe(fOe));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Ends half a cycle after an edge so outputs are settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic put(input logic [2:0] v, input logic g, input int n);
		@(posedge clk_sys);
		want <= v;
		gang <= g;
		tick(n);
	endtask
	task automatic end_of_test;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial forever #5 clk_sys = ~clk_sys;
	initial begin
		#400000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			r = 3'($random(seed));
			expQ.push_back((i > 17) ? {3{r[0]}} : r);
			put(r, i > 17, HOLD);
			chk(8'(sink), 8'(expQ[0]));
			chk(8'(sb), 8'(expQ.pop_front() == 3'h0));
		end
		$display("test 1 done");
		put(3'h1, 1'b0, 10);
		put(3'h0, 1'b0, SB - 10);
		put(3'h4, 1'b0, 6);
		put(3'h0, 1'b0, SB - 10);
		chk(8'(sb), 8'h0);
		tick(30);
		chk(8'(sb), 8'h1);
		put(3'h2, 1'b0, 10);
		chk(8'(sb), 8'h0);
		chk(8'(lvl[15:8] != 8'h00 && lvl[15:8] < 8'h80), 8'h1);
		tick(SS + 5);
		chk(lvl[15:8], 8'hFF);
		$display("test 2 done");
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			{uv, ot, shrt[2], open[0]} <= 4'h1 << k;
			put((k > 1) ? 3'h7 : 3'h0, 1'b0, 10);
			chk({6'h0, irq, fOut}, 8'h2);
			chk(8'(sink), 8'h0);
			@(posedge clk_sys);
			{uv, ot, shrt[2], open[0]} <= 4'h0;
			tick(10);
			chk(8'(irq), 8'h0);
		end
		$display("test 3 done");
		put(3'h7, 1'b0, 10);
		@(posedge clk_sys);
		open <= 3'h2;
		tick(DG + 15);
		chk(8'(sink), 8'h0);
		@(posedge clk_sys);
		open <= 3'h0;
		tick(HC + 25);
		chk(8'(sink), 8'h7);
		@(posedge clk_sys);
		open <= 3'h1;
		for (int p = 0; p < 7; p++) begin
			put(3'h0, 1'b0, 8);
			put(3'h1, 1'b0, 12);
		end
		chk(8'(sink), 8'h0);
		@(posedge clk_sys);
		open <= 3'h0;
		tick(HC + 25);
		chk(8'(sink), 8'h1);
		$display("test 4 done");
		end_of_test;
	end
endmodule
bind tcd_ctrl tcd_ctrl_sva #(.STANDBY_CYC(STANDBY_CYC), .SOFTSTART_CYC(SOFTSTART_CYC)) sva (
	.clk_sys(clk_sys), .reset_n(reset_n), .dimmingInputs(dimmingInputs), .openSense(openSense),
	.shortSense(shortSense), .overTempSense(overTempSense),
	.undervoltageLockout(undervoltageLockout), .sinkOutputs(sinkOutputs), .sinkLevel(sinkLevel),
	.standby(standby), .faultLineOut(faultLineOut), .faultLineOe(faultLineOe));
